/* File: logic/ucev_top.sv */
// Control endpoint stage tracking and USB event flags behind AHB-Lite.
// Assumes packet-level event pulses from a link engine on clk_in; bus
// suspend and resume arrive as asynchronous levels.
// What this block does
// - Setup packet sets setup flag, not bank0
// - Setup flag clears other status bits, interrupts
// - Direction bit zero during setup stage
// - Control endpoint full duplex, others one-way
// - Host accept sets IN done; firmware clears
// - OUT stage: bank0 flag set on valid packet
// - Status stage returns direction bit to zero
// - Write/no-data status is zero-length IN
// - Read status is zero-length OUT
// - Priority from high and low bits, 0-3
// - Second-bank OUT sets bank1 flag
// - Stall sent flag; cleared by setup
// - Start of frame sets frame flag
// - Resume after suspend sets wake flag
// - Suspend detected sets sleep flag
// - Enabled flags drive one interrupt request
// - Endpoint enable bits 0 to 6
// - Enable bit 7 reads zero
//
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module ucev_top #(
    parameter int NUM_EP = ucev_pkg::NUM_EP // Endpoints with enables
) (
    input wire logic clk_in, // 100 MHz clock
    input wire logic resetn_in, // Sync reset, active low
    input wire logic hsel_in, // AHB select
    input wire logic [31:0] haddr_in, // AHB address
    input wire logic [1:0] htrans_in, // AHB transfer type
    input wire logic hwrite_in, // AHB write
    input wire logic [2:0] hsize_in, // AHB size
    input wire logic [31:0] hwdata_in, // AHB write data
    input wire logic hready_in, // AHB bus ready
    output logic [31:0] hrdata_out, // AHB read data
    output logic hreadyout_out, // AHB slave ready
    output logic hresp_out, // AHB response, always OKAY
    input wire logic setup_rx_in, // Setup packet accepted, pulse
    input wire logic out_rx_in, // OUT packet accepted, pulse
    input wire logic out_bank_in, // Bank of accepted OUT packet
    input wire logic in_ack_in, // Host acked IN packet, pulse
    input wire logic stall_done_in, // Stall handshake sent, pulse
    input wire logic sof_in, // Start of frame, pulse
    input wire logic [NUM_EP-1:0] ep_event_in, // Other endpoint events
    input wire logic suspend_in, // Bus suspend level, async
    input wire logic resume_in, // Bus resume level, async
    output logic in_send_out, // IN packet may be sent
    output logic stall_req_out, // Request STALL handshake
    output logic ep_dir_out, // Control data-stage direction
    output logic fifo_release_out, // Endpoint FIFO freed, pulse
    output logic usb_irq_out, // USB interrupt request
    output logic [1:0] usb_priority_out // Interrupt priority 0..3
);
    typedef struct packed {
        logic addr_ok;
        logic wr;
        logic [9:0] addr;
        logic [7:0] eps;
        logic [7:0] gstat;
        logic [7:0] gen;
        logic [7:0] epen;
        logic [NUM_EP-1:0] epev;
        logic [1:0] prio;
        logic suspended;
        ucev_pkg::ucev_stage_t stage;
        logic [31:0] rdata;
        logic irq;
        logic release_p;
    } ucev_top_t;
    ucev_top_t r, next_r;
    logic susp_sync, res_sync, susp_rise, res_rise;
    logic wr_eps, wr_gs, wr_ev;
    logic [7:0] wv, rd_byte;
    logic ep0_pend;

    ucev_sync u_sync_susp (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .d_in(suspend_in),
        .q_out(susp_sync)
    );
    ucev_sync u_sync_res (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .d_in(resume_in),
        .q_out(res_sync)
    );
    ucev_pulse u_pulse_susp (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .level_in(susp_sync),
        .pulse_out(susp_rise)
    );
    ucev_pulse u_pulse_res (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .level_in(res_sync),
        .pulse_out(res_rise)
    );

    always_comb
    begin
        next_r = r;
        wv = hwdata_in[7:0];
        wr_eps = r.wr && (r.addr == ucev_pkg::ADDR_EP0_STATUS);
        wr_gs = r.wr && (r.addr == ucev_pkg::ADDR_GLOBAL_STATUS);
        wr_ev = r.wr && (r.addr == ucev_pkg::ADDR_EP_EVENT);
        next_r.release_p = 1'b0;
        // Data phase of a write: flags clear on zero writes, control bits load
        if (r.wr)
        begin
            if (r.addr == ucev_pkg::ADDR_GLOBAL_IRQ_EN)
                next_r.gen = wv & ucev_pkg::GLOBAL_MASK;
            else if (r.addr == ucev_pkg::ADDR_EP_IRQ_EN)
                next_r.epen = wv & ucev_pkg::EP_EN_MASK;
            else if (r.addr == ucev_pkg::ADDR_PRIORITY)
                next_r.prio = wv[1:0];
        end
        if (wr_eps)
        begin
            next_r.eps[ucev_pkg::EPS_DIR] = wv[ucev_pkg::EPS_DIR];
            next_r.eps[ucev_pkg::EPS_STALL_REQ] = wv[ucev_pkg::EPS_STALL_REQ];
            next_r.eps[ucev_pkg::EPS_IN_READY] = r.eps[ucev_pkg::EPS_IN_READY]
                | wv[ucev_pkg::EPS_IN_READY];
            next_r.eps[ucev_pkg::EPS_IN_DONE] = r.eps[ucev_pkg::EPS_IN_DONE]
                & wv[ucev_pkg::EPS_IN_DONE];
            next_r.eps[ucev_pkg::EPS_OUT_BANK0] = r.eps[ucev_pkg::EPS_OUT_BANK0]
                & wv[ucev_pkg::EPS_OUT_BANK0];
            next_r.eps[ucev_pkg::EPS_OUT_BANK1] = r.eps[ucev_pkg::EPS_OUT_BANK1]
                & wv[ucev_pkg::EPS_OUT_BANK1];
            next_r.eps[ucev_pkg::EPS_SETUP] = r.eps[ucev_pkg::EPS_SETUP]
                & wv[ucev_pkg::EPS_SETUP];
            next_r.eps[ucev_pkg::EPS_STALL_SENT] = r.eps[ucev_pkg::EPS_STALL_SENT]
                & wv[ucev_pkg::EPS_STALL_SENT];
            // Clearing the setup or bank0 flag frees the FIFO; clearing bank1 does not
            next_r.release_p = (r.eps[ucev_pkg::EPS_SETUP] & ~wv[ucev_pkg::EPS_SETUP])
                | (r.eps[ucev_pkg::EPS_OUT_BANK0] & ~wv[ucev_pkg::EPS_OUT_BANK0]);
            if (wv[ucev_pkg::EPS_DIR] && r.stage == ucev_pkg::UCEV_SETUP
                && !r.eps[ucev_pkg::EPS_SETUP])
                next_r.stage = ucev_pkg::UCEV_DATA;
        end
        if (wr_gs)
            next_r.gstat = r.gstat & wv;
        if (wr_ev)
            next_r.epev = r.epev & wv[NUM_EP-1:0];
        // Hardware sets take priority over software clears
        next_r.epev = next_r.epev | ep_event_in;
        if (in_ack_in && r.eps[ucev_pkg::EPS_IN_READY])
        begin
            next_r.eps[ucev_pkg::EPS_IN_DONE] = 1'b1;
            next_r.eps[ucev_pkg::EPS_IN_READY] = 1'b0;
            // Zero-length IN ends a write or no-data transfer
            if (r.stage == ucev_pkg::UCEV_STATUS || !r.eps[ucev_pkg::EPS_DIR])
                next_r.stage = ucev_pkg::UCEV_SETUP;
            else
                next_r.stage = ucev_pkg::UCEV_STATUS;
        end
        if (out_rx_in)
        begin
            if (out_bank_in)
                next_r.eps[ucev_pkg::EPS_OUT_BANK1] = 1'b1;
            else
                next_r.eps[ucev_pkg::EPS_OUT_BANK0] = 1'b1;
            // OUT during an IN data or status stage closes the transfer
            if (r.eps[ucev_pkg::EPS_DIR] || r.stage == ucev_pkg::UCEV_STATUS)
            begin
                next_r.stage = ucev_pkg::UCEV_SETUP;
                next_r.eps[ucev_pkg::EPS_DIR] = 1'b0;
            end
        end
        if (stall_done_in && r.eps[ucev_pkg::EPS_STALL_REQ])
            next_r.eps[ucev_pkg::EPS_STALL_SENT] = 1'b1;
        if (next_r.stage == ucev_pkg::UCEV_STATUS)
            next_r.eps[ucev_pkg::EPS_DIR] = 1'b0;
        if (setup_rx_in)
        begin
            next_r.eps = 8'h00;
            next_r.eps[ucev_pkg::EPS_SETUP] = 1'b1;
            next_r.stage = ucev_pkg::UCEV_SETUP;
        end
        if (sof_in)
            next_r.gstat[ucev_pkg::GS_FRAME] = 1'b1;
        if (susp_rise)
        begin
            next_r.gstat[ucev_pkg::GS_SLEEP] = 1'b1;
            next_r.suspended = 1'b1;
        end
        if (res_rise && r.suspended)
        begin
            next_r.gstat[ucev_pkg::GS_RESUME] = 1'b1;
            next_r.suspended = 1'b0;
        end
        // One request line, each source gated by its enable
        ep0_pend = |{r.eps[ucev_pkg::EPS_IN_DONE], r.eps[ucev_pkg::EPS_OUT_BANK0],
            r.eps[ucev_pkg::EPS_OUT_BANK1], r.eps[ucev_pkg::EPS_SETUP],
            r.eps[ucev_pkg::EPS_STALL_SENT]};
        next_r.irq = (ep0_pend & r.epen[0])
            | (|(r.epev[NUM_EP-1:1] & r.epen[NUM_EP-1:1]))
            | (|(r.gstat & r.gen));
        // Address phase
        next_r.wr = 1'b0;
        if (hsel_in && hready_in && htrans_in[1])
        begin
            next_r.addr = haddr_in[9:0];
            next_r.wr = hwrite_in;
            next_r.addr_ok = (haddr_in[31:10] == 22'h000000);
            if (!next_r.addr_ok)
                next_r.wr = 1'b0;
            rd_byte = 8'h00;
            if (!next_r.addr_ok)
                rd_byte = 8'h00;
            else if (haddr_in[9:0] == ucev_pkg::ADDR_EP0_STATUS)
                rd_byte = next_r.eps;
            else if (haddr_in[9:0] == ucev_pkg::ADDR_GLOBAL_STATUS)
                rd_byte = next_r.gstat;
            else if (haddr_in[9:0] == ucev_pkg::ADDR_GLOBAL_IRQ_EN)
                rd_byte = next_r.gen;
            else if (haddr_in[9:0] == ucev_pkg::ADDR_EP_IRQ_EN)
                rd_byte = next_r.epen;
            else if (haddr_in[9:0] == ucev_pkg::ADDR_PRIORITY)
                rd_byte = {6'h00, next_r.prio};
            else if (haddr_in[9:0] == ucev_pkg::ADDR_EP_EVENT)
                rd_byte = 8'(next_r.epev);
            next_r.rdata = {24'h000000, rd_byte};
        end
        else
        begin
            rd_byte = 8'h00;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!resetn_in)
        begin
            r <= '0;
            r.stage <= ucev_pkg::UCEV_SETUP;
        end
        else
            r <= next_r;
    end

    assign hrdata_out = r.rdata;
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;
    assign in_send_out = r.eps[ucev_pkg::EPS_IN_READY];
    assign stall_req_out = r.eps[ucev_pkg::EPS_STALL_REQ];
    assign ep_dir_out = r.eps[ucev_pkg::EPS_DIR];
    assign fifo_release_out = r.release_p;
    assign usb_irq_out = r.irq;
    assign usb_priority_out = r.prio;

    property p_setup_flags;
        @(posedge clk_in) disable iff (!resetn_in)
        setup_rx_in |=> r.eps == 8'h04;
    endproperty
    a_setup_flags: assert property (p_setup_flags) else $error("setup flag wrong");
    property p_setup_dir;
        @(posedge clk_in) disable iff (!resetn_in)
        setup_rx_in |=> !ep_dir_out && r.stage == ucev_pkg::UCEV_SETUP;
    endproperty
    a_setup_dir: assert property (p_setup_dir) else $error("dir not zero in setup");
    property p_in_done;
        @(posedge clk_in) disable iff (!resetn_in)
        in_ack_in && in_send_out && !setup_rx_in |=> r.eps[0] && !in_send_out;
    endproperty
    a_in_done: assert property (p_in_done) else $error("in done not set");
    property p_sof;
        @(posedge clk_in) disable iff (!resetn_in)
        sof_in |=> r.gstat[3];
    endproperty
    a_sof: assert property (p_sof) else $error("frame flag missed");
    property p_bank1;
        @(posedge clk_in) disable iff (!resetn_in)
        out_rx_in && out_bank_in && !setup_rx_in |=> r.eps[6];
    endproperty
    a_bank1: assert property (p_bank1) else $error("bank1 flag missed");
    property p_status_dir;
        @(posedge clk_in) disable iff (!resetn_in)
        r.stage == ucev_pkg::UCEV_STATUS |-> !ep_dir_out;
    endproperty
    a_status_dir: assert property (p_status_dir) else $error("dir set in status");
    property p_out_status;
        @(posedge clk_in) disable iff (!resetn_in)
        out_rx_in && !setup_rx_in && r.stage == ucev_pkg::UCEV_STATUS
            |=> r.stage == ucev_pkg::UCEV_SETUP;
    endproperty
    a_out_status: assert property (p_out_status) else $error("status stage not closed");
    property p_ep_en_bit7;
        @(posedge clk_in) disable iff (!resetn_in)
        !r.epen[7];
    endproperty
    a_ep_en_bit7: assert property (p_ep_en_bit7) else $error("reserved bit set");
    property p_irq_gate;
        @(posedge clk_in) disable iff (!resetn_in)
        (r.gen == 8'h00 && r.epen == 8'h00) |=> !usb_irq_out;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");
    property p_sticky;
        @(posedge clk_in) disable iff (!resetn_in)
        r.gstat[3] && !wr_gs |=> r.gstat[3];
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag lost");
    c_setup: cover property (@(posedge clk_in) setup_rx_in);
    c_in: cover property (@(posedge clk_in) in_ack_in && in_send_out);
    c_irq: cover property (@(posedge clk_in) usb_irq_out);
endmodule
`default_nettype wire

/* File: logic/ucev_pkg.sv */
// Package for the control endpoint event block: register map, fields, resets.
// Assumes a 32-bit AHB-Lite register bus and a single control endpoint.
`default_nettype none
package ucev_pkg;
    // Register byte addresses (printed offsets are word indices, x4)
    localparam logic [7:0] GLOBAL_IRQ_EN_IDX = 8'hBE;
    localparam logic [7:0] EP_IRQ_EN_IDX = 8'hC2;
    localparam logic [9:0] ADDR_GLOBAL_IRQ_EN = {GLOBAL_IRQ_EN_IDX, 2'b00};
    localparam logic [9:0] ADDR_EP_IRQ_EN = {EP_IRQ_EN_IDX, 2'b00};
    localparam logic [9:0] ADDR_EP0_STATUS = 10'h010;
    localparam logic [9:0] ADDR_GLOBAL_STATUS = 10'h014;
    localparam logic [9:0] ADDR_PRIORITY = 10'h018;
    localparam logic [9:0] ADDR_EP_EVENT = 10'h01C;
    // Endpoint status/control field positions
    localparam int EPS_OUT_BANK0 = 1;
    localparam int EPS_SETUP = 2;
    localparam int EPS_STALL_SENT = 3;
    localparam int EPS_IN_READY = 4;
    localparam int EPS_STALL_REQ = 5;
    localparam int EPS_OUT_BANK1 = 6;
    localparam int EPS_DIR = 7;
    localparam int EPS_IN_DONE = 0;
    // Global status field positions
    localparam int GS_SLEEP = 0;
    localparam int GS_FRAME = 3;
    localparam int GS_RESUME = 5;
    localparam logic [7:0] GLOBAL_MASK = 8'h29;
    localparam logic [7:0] EP_EN_MASK = 8'h7F;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [1:0] RESET_PRIO = 2'h0;
    localparam int NUM_EP = 7;
    // Control transfer stages
    typedef enum logic [1:0] {
        UCEV_SETUP = 2'b00,
        UCEV_DATA = 2'b01,
        UCEV_STATUS = 2'b10
    } ucev_stage_t;
endpackage
`default_nettype wire

/* File: logic/ucev_sync.sv */
// Two-flop synchroniser for one level from outside the clock domain.
// Assumes the input is quasi-static relative to clk_in.
`timescale 1ns/1ns
`default_nettype none
module ucev_sync (
    input wire logic clk_in, // Clock
    input wire logic resetn_in, // Sync reset, active low
    input wire logic d_in, // Async level
    output logic q_out // Synchronised level
);
    typedef struct packed {
        logic meta;
        logic sync;
    } ucev_sync_t;
    ucev_sync_t r, next_r;
    always_comb
    begin
        next_r.meta = d_in;
        next_r.sync = r.meta;
    end
    always_ff @(posedge clk_in)
    begin
        if (!resetn_in)
            r <= '0;
        else
            r <= next_r;
    end
    assign q_out = r.sync;
endmodule
`default_nettype wire

/* File: logic/ucev_pulse.sv */
// Rising-edge pulse from a synchronised level, one cycle wide.
// Assumes the input is already in the clk_in domain.
`timescale 1ns/1ns
`default_nettype none
module ucev_pulse (
    input wire logic clk_in, // Clock
    input wire logic resetn_in, // Sync reset, active low
    input wire logic level_in, // Synchronised level
    output logic pulse_out // Rising edge pulse
);
    typedef struct packed {
        logic last;
    } ucev_pulse_t;
    ucev_pulse_t r, next_r;
    always_comb
    begin
        next_r.last = level_in;
    end
    always_ff @(posedge clk_in)
    begin
        if (!resetn_in)
            r <= '0;
        else
            r <= next_r;
    end
    assign pulse_out = level_in & ~r.last;
endmodule
`default_nettype wire

/* File: bench/ucev_host_model.sv */
// Model of the host and link engine facing the control endpoint block.
// Assumes the bench calls its tasks just after a rising edge of clk_in.
`timescale 1ns/1ns
`default_nettype none
module ucev_host_model (
    input wire logic clk_in, // Clock
    output logic setup_rx_out, // Setup packet accepted
    output logic out_rx_out, // OUT packet accepted
    output logic out_bank_out, // Bank of OUT packet
    output logic in_ack_out, // Host acked IN packet
    output logic stall_done_out, // Stall handshake sent
    output logic sof_out, // Start of frame
    output logic [6:0] ep_event_out, // Other endpoint events
    output logic suspend_out, // Bus suspend level
    output logic resume_out // Bus resume level
);
    initial
    begin
        {setup_rx_out, out_rx_out, out_bank_out, in_ack_out} = 4'h0;
        {stall_done_out, sof_out, suspend_out, resume_out} = 4'h0;
        ep_event_out = 7'h00;
    end
    // Kind 0 setup, 1 OUT, 2 IN ack, 3 stall sent, 4 frame start
    task automatic pkt(input int kind, input logic bank);
        @(posedge clk_in);
        case (kind)
            0: setup_rx_out <= 1'b1;
            1:
            begin
                out_rx_out <= 1'b1;
                out_bank_out <= bank;
            end
            2: in_ack_out <= 1'b1;
            3: stall_done_out <= 1'b1;
            default: sof_out <= 1'b1;
        endcase
        @(posedge clk_in);
        {setup_rx_out, out_rx_out, in_ack_out, stall_done_out, sof_out} <= 5'h00;
        // Bank line is meaningless outside a packet
        out_bank_out <= ~bank;
    endtask
    task automatic evt(input logic [6:0] v);
        @(posedge clk_in);
        ep_event_out <= v;
        @(posedge clk_in);
        ep_event_out <= 7'h00;
    endtask
    // Levels pass a two-flop synchroniser, so hold them a while
    task automatic lvl(input logic s, input logic r);
        @(posedge clk_in);
        suspend_out <= s;
        resume_out <= r;
        repeat (6) @(posedge clk_in);
    endtask
endmodule
`default_nettype wire

/* File: bench/tb.sv */
// Self-checking bench: AHB-Lite firmware side plus host model.
// Assumes zero-wait registered reads and the register map of ucev_pkg.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin bad_count++; \
$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata_out;
    logic hreadyout_out;
    logic hresp_out;
    logic setup_rx, out_rx, out_bank, in_ack, stall_done, sof, susp, resm;
    logic [6:0] ep_event;
    logic in_send_out, stall_req_out, ep_dir_out, fifo_release_out, usb_irq_out;
    logic [1:0] usb_priority_out;
    logic rd_dphase = 1'b0;
    logic [31:0] exp_q[$];
    logic [31:0] exp_val;
    logic [6:0] ev;
    int bad_count = 0;
    int total_checks = 0;
    int rel_count = 0;
    int cycles = 0;
    int seed = 56474;
    always #5 clk_in = ~clk_in;
    ucev_top ucev_top_i (.clk_in(clk_in), .resetn_in(resetn_in), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
        .hwdata_in(hwdata), .hready_in(hreadyout_out), .hrdata_out(hrdata_out),
        .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .setup_rx_in(setup_rx),
        .out_rx_in(out_rx), .out_bank_in(out_bank), .in_ack_in(in_ack),
        .stall_done_in(stall_done), .sof_in(sof), .ep_event_in(ep_event),
        .suspend_in(susp), .resume_in(resm), .in_send_out(in_send_out),
        .stall_req_out(stall_req_out), .ep_dir_out(ep_dir_out),
        .fifo_release_out(fifo_release_out), .usb_irq_out(usb_irq_out),
        .usb_priority_out(usb_priority_out));
    ucev_host_model ucev_host_model_i (.clk_in(clk_in), .setup_rx_out(setup_rx),
        .out_rx_out(out_rx), .out_bank_out(out_bank), .in_ack_out(in_ack),
        .stall_done_out(stall_done), .sof_out(sof), .ep_event_out(ep_event),
        .suspend_out(susp), .resume_out(resm));
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic ahb(input logic w, input logic [9:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {22'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge clk_in);
        while (hreadyout_out !== 1'b1) @(posedge clk_in);
        htrans <= 2'h0;
        hwdata <= d;
        rd_dphase <= ~w;
        if (!w)
            exp_q.push_back(d);
        @(posedge clk_in);
        while (hreadyout_out !== 1'b1) @(posedge clk_in);
        rd_dphase <= 1'b0;
    endtask
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
    endtask
    task automatic rd(input logic [9:0] a, input logic [31:0] e);
        ahb(1'b0, a, e);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    // Read data is compared against the oldest expectation
    always @(posedge clk_in)
        if (rd_dphase === 1'b1 && hreadyout_out === 1'b1)
        begin
            exp_val = exp_q.pop_front();
            `CHK(hrdata_out, exp_val)
        end
    always @(posedge clk_in)
        if (fifo_release_out === 1'b1)
            rel_count <= rel_count + 1;
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            end_sim();
        end
    end
    initial
    begin
        tick(5);
        resetn_in <= 1'b1;
        rd(ucev_pkg::ADDR_GLOBAL_IRQ_EN, 32'h0);
        rd(ucev_pkg::ADDR_EP_IRQ_EN, 32'h0);
        rd(ucev_pkg::ADDR_EP0_STATUS, 32'h0);
        rd(ucev_pkg::ADDR_GLOBAL_STATUS, 32'h0);
        rd(10'h100, 32'h0);
        `CHK(({hreadyout_out, hresp_out}), 2'h2)
        wr(ucev_pkg::ADDR_EP_IRQ_EN, 32'hFF);
        rd(ucev_pkg::ADDR_EP_IRQ_EN, 32'h7F);
        wr(ucev_pkg::ADDR_GLOBAL_IRQ_EN, 32'hFF);
        rd(ucev_pkg::ADDR_GLOBAL_IRQ_EN, {24'h0, ucev_pkg::GLOBAL_MASK});
        wr(ucev_pkg::ADDR_GLOBAL_IRQ_EN, 32'h0);
        wr(ucev_pkg::ADDR_EP_IRQ_EN, 32'h01);
        for (int p = 0; p < 4; p++)
        begin
            wr(ucev_pkg::ADDR_PRIORITY, 32'(p));
            rd(ucev_pkg::ADDR_PRIORITY, 32'(p));
            `CHK(usb_priority_out, 2'(p))
        end
        // Setup wipes direction, ready and stall request
        wr(ucev_pkg::ADDR_EP0_STATUS, 32'hB0);
        tick(1);
        `CHK(({ep_dir_out, in_send_out, stall_req_out}), 3'h7)
        ucev_host_model_i.pkt(0, 1'b0);
        rd(ucev_pkg::ADDR_EP0_STATUS, 32'h04);
        `CHK(({ep_dir_out, in_send_out, stall_req_out}), 3'h0)
        `CHK(usb_irq_out, 1'b1)
        wr(ucev_pkg::ADDR_EP0_STATUS, 32'h0);
        tick(2);
        `CHK(usb_irq_out, 1'b0)
        `CHK(rel_count, 1)
        // Control read: IN data, then zero-length OUT status
        wr(ucev_pkg::ADDR_EP0_STATUS, 32'h80);
        ucev_host_model_i.pkt(2, 1'b0);
        rd(ucev_pkg::ADDR_EP0_STATUS, 32'h80);
        wr(ucev_pkg::ADDR_EP0_STATUS, 32'h90);
        tick(1);
        `CHK(in_send_out, 1'b1)
        ucev_host_model_i.pkt(2, 1'b0);
        rd(ucev_pkg::ADDR_EP0_STATUS, 32'h01);
        wr(ucev_pkg::ADDR_EP0_STATUS, 32'h80);
        rd(ucev_pkg::ADDR_EP0_STATUS, 32'h00);
        ucev_host_model_i.pkt(1, 1'b0);
        rd(ucev_pkg::ADDR_EP0_STATUS, 32'h02);
        `CHK(ep_dir_out, 1'b0)
        // Back in setup stage, so the direction bit is writable again
        wr(ucev_pkg::ADDR_EP0_STATUS, 32'h80);
        rd(ucev_pkg::ADDR_EP0_STATUS, 32'h80);
        wr(ucev_pkg::ADDR_EP0_STATUS, 32'h0);
        // Control write: OUT data in both banks, then zero-length IN
        ucev_host_model_i.pkt(0, 1'b0);
        wr(ucev_pkg::ADDR_EP0_STATUS, 32'h0);
        ucev_host_model_i.pkt(1, 1'b1);
        rd(ucev_pkg::ADDR_EP0_STATUS, 32'h40);
        ucev_host_model_i.pkt(1, 1'b0);
        rd(ucev_pkg::ADDR_EP0_STATUS, 32'h42);
        wr(ucev_pkg::ADDR_EP0_STATUS, 32'h0);
        wr(ucev_pkg::ADDR_EP0_STATUS, 32'h10);
        ucev_host_model_i.pkt(2, 1'b0);
        rd(ucev_pkg::ADDR_EP0_STATUS, 32'h01);
        wr(ucev_pkg::ADDR_EP0_STATUS, 32'h0);
        tick(2);
        `CHK(rel_count, 4)
        // Stall handshake, then setup clears the sent flag
        ucev_host_model_i.pkt(3, 1'b0);
        wr(ucev_pkg::ADDR_EP0_STATUS, 32'h20);
        rd(ucev_pkg::ADDR_EP0_STATUS, 32'h20);
        `CHK(stall_req_out, 1'b1)
        ucev_host_model_i.pkt(3, 1'b0);
        rd(ucev_pkg::ADDR_EP0_STATUS, 32'h28);
        ucev_host_model_i.pkt(0, 1'b0);
        rd(ucev_pkg::ADDR_EP0_STATUS, 32'h04);
        wr(ucev_pkg::ADDR_EP0_STATUS, 32'h0);
        // Global events
        wr(ucev_pkg::ADDR_EP_IRQ_EN, 32'h0);
        wr(ucev_pkg::ADDR_GLOBAL_IRQ_EN, 32'h08);
        ucev_host_model_i.pkt(4, 1'b0);
        tick(2);
        `CHK(usb_irq_out, 1'b1)
        ucev_host_model_i.lvl(1'b1, 1'b0);
        ucev_host_model_i.lvl(1'b0, 1'b1);
        tick(20);
        rd(ucev_pkg::ADDR_GLOBAL_STATUS, 32'h29);
        wr(ucev_pkg::ADDR_GLOBAL_STATUS, 32'h0);
        rd(ucev_pkg::ADDR_GLOBAL_STATUS, 32'h0);
        tick(2);
        `CHK(usb_irq_out, 1'b0)
        // Other endpoint events gated per endpoint
        wr(ucev_pkg::ADDR_GLOBAL_IRQ_EN, 32'h0);
        ev = 7'($random(seed)) | 7'h04;
        ucev_host_model_i.evt(ev);
        rd(ucev_pkg::ADDR_EP_EVENT, {25'h0, ev});
        `CHK(usb_irq_out, 1'b0)
        wr(ucev_pkg::ADDR_EP_IRQ_EN, 32'h7E);
        tick(2);
        `CHK(usb_irq_out, 1'b1)
        end_sim();
    end
endmodule
`default_nettype wire
